/* core/sal_pkg.sv */
// Package of constants, types and register map for the station alias loader
package sal_pkg;

   // ************************************************************
   // Register offsets in the slave register space
   // ************************************************************
   localparam logic [15:0] SAL_ADDR_CFG_ALIAS  = 16'h0012; // Configured alias, read only
   localparam logic [15:0] SAL_ADDR_AL_CTRL    = 16'h0120; // Application layer control
   localparam logic [15:0] SAL_ADDR_AL_STATE   = 16'h0130; // Application layer state
   localparam logic [15:0] SAL_ADDR_AL_CODE    = 16'h0134; // Application layer state code
   localparam logic [15:0] SAL_ADDR_HIGH_SET   = 16'h3740; // Stored alias high byte setting
   localparam logic [15:0] SAL_ADDR_SRC_SEL    = 16'h3741; // Alias source selection setting

   // ************************************************************
   // Field positions, values and reset values
   // ************************************************************
   localparam int          SAL_ID_BIT          = 5;        // ID request / ID loaded bit
   localparam logic [15:0] SAL_SII_ALIAS_WORD  = 16'h0004; // SII word holding the alias
   localparam logic [15:0] SAL_SEL_SWITCH      = 16'h0000; // Switch based alias
   localparam logic [15:0] SAL_SEL_SII         = 16'h0001; // SII stored alias
   localparam logic [15:0] SAL_SEL_RESERVED    = 16'h0002; // Manufacturer use only
   localparam logic [15:0] SAL_SEL_RESET       = 16'h0001; // Selection default
   localparam logic [15:0] SAL_HIGH_RESET      = 16'h0000; // High byte default
   localparam logic [15:0] SAL_HIGH_MAX        = 16'h00ff; // Largest high byte accepted
   localparam logic [15:0] SAL_ZERO            = 16'h0000; // Cleared register value

   // ************************************************************
   // Carrier types
   // ************************************************************
   typedef struct packed {
      logic        rd;    // Read strobe, one cycle
      logic        wr;    // Write strobe, one cycle
      logic [15:0] addr;  // Register offset
      logic [15:0] wdata; // Write data
   } sal_reg_req_t;

   typedef struct packed {
      logic        valid; // One cycle store pulse
      logic [15:0] index; // Setting index being stored
      logic [15:0] data;  // Value to keep in backup memory
   } sal_store_t;

   typedef struct packed {
      logic        req;   // Held high until acknowledged
      logic [15:0] addr;  // Word address or setting index
   } sal_fetch_req_t;

   typedef struct packed {
      logic        ack;   // One cycle answer strobe
      logic [15:0] data;  // Word returned with ack
   } sal_fetch_ans_t;

   // Power-on sequence states
   typedef enum logic [2:0] {
      SAL_ST_SEL_GO, SAL_ST_SEL_WAIT, SAL_ST_HIGH_GO, SAL_ST_HIGH_WAIT,
      SAL_ST_SII_GO, SAL_ST_SII_WAIT, SAL_ST_RUN
   } sal_state_t;

endpackage

/* core/sal_word_fetch.sv */
// Word fetch client: one request/acknowledge read from a word memory
module sal_word_fetch
   import sal_pkg::*;
(
   input  wire logic           i_core_clk,
   input  wire logic           i_rst_n,
   input  wire logic           i_start,
   input  wire logic [15:0]    i_addr,
   output sal_fetch_req_t      o_fetch,
   input  wire sal_fetch_ans_t i_answer,
   output logic                o_done,
   output logic [15:0]         o_data
);

   // ************************************************************
   // Request holding and answer capture
   // ************************************************************
   sal_fetch_req_t fetch;      // Outstanding request
   sal_fetch_req_t next_fetch;
   logic           done;       // Answer arrived last cycle
   logic           next_done;
   logic [15:0]    data;       // Captured word
   logic [15:0]    next_data;

   // Next values: start raises the request, ack drops it and captures
   always_comb begin
      next_fetch = fetch;
      next_done  = 1'b0;
      next_data  = data;
      if (fetch.req && i_answer.ack) begin
         // Ack wins over a start in the same cycle; caller never overlaps
         next_fetch.req = 1'b0;
         next_done      = 1'b1;
         next_data      = i_answer.data;
      end else if (i_start) begin
         next_fetch.req  = 1'b1;
         next_fetch.addr = i_addr;
      end
   end

   // Registers
   always_ff @(posedge i_core_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         fetch <= '0;
         done  <= 1'b0;
         data  <= 16'h0000;
      end else begin
         fetch <= next_fetch;
         done  <= next_done;
         data  <= next_data;
      end
   end

   assign o_fetch = fetch;
   assign o_done  = done;
   assign o_data  = data;

endmodule

/* core/sal_station_alias_loader.sv */
// Station alias loader: power-on alias load and explicit device ID handshake
// Summary of operation
// - Fetch source selection from backup memory first
// - Selection 1: copy SII word 0004h to 0012h
// - Selection 0: write switch-based alias to 0012h
// - Refuse writing reserved selection value 2
// - Selection setting defaults to 1
// - Switch and high byte zero give alias 0
// - Switch in low byte, high setting upper
// - High byte setting accepts only 0 to 255
// - Settings sampled only at control power-on
// - ID request bit5 puts switch-based alias in 0134h
// - Then set ID loaded bit5 in 0130h
// - Request low drives ID loaded back low
// - Handshake end clears the state code register
// - Handshake never alters the configured alias
// - Communication alarm code replaces alias while returning
// - Alarm cleared: alias presented again
module sal_station_alias_loader
   import sal_pkg::*;
(
   input  wire logic           i_core_clk,
   input  wire logic           i_rst_n,
   input  wire sal_reg_req_t   i_reg,
   output logic [15:0]         o_reg_rdata,
   input  wire logic [7:0]     i_rotary_switch,
   input  wire logic [7:0]     i_comm_alarm_group_a,
   input  wire logic [7:0]     i_comm_alarm_group_b,
   input  wire logic [7:0]     i_comm_alarm_group_c,
   input  wire logic [15:0]    i_comm_alarm_code,
   output sal_fetch_req_t      o_nv_fetch,
   input  wire sal_fetch_ans_t i_nv_answer,
   output sal_fetch_req_t      o_sii_fetch,
   input  wire sal_fetch_ans_t i_sii_answer,
   output sal_store_t          o_store,
   output logic                o_alias_ready
);

   // ************************************************************
   // Reset release
   // ************************************************************
   logic [1:0] rst_pipe;   // Release synchroniser, assertion stays asynchronous
   logic       rst_n;      // Reset copy used by the rest of the block

   always_ff @(posedge i_core_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         rst_pipe <= 2'b00;
      end else begin
         rst_pipe <= {rst_pipe[0], 1'b1};
      end
   end
   assign rst_n = rst_pipe[1];

   // ************************************************************
   // Backup memory and SII fetch clients
   // ************************************************************
   logic        nv_start;   // Start a backup memory read
   logic [15:0] nv_index;   // Setting index to read
   logic        nv_done;    // Backup word arrived
   logic [15:0] nv_data;    // Backup word
   logic        sii_start;  // Start the SII alias read
   logic        sii_done;   // SII word arrived
   logic [15:0] sii_data;   // SII word

   sal_word_fetch u_nv_fetch (
      .i_core_clk (i_core_clk),
      .i_rst_n    (rst_n),
      .i_start    (nv_start),
      .i_addr     (nv_index),
      .o_fetch    (o_nv_fetch),
      .i_answer   (i_nv_answer),
      .o_done     (nv_done),
      .o_data     (nv_data)
   );

   sal_word_fetch u_sii_fetch (
      .i_core_clk (i_core_clk),
      .i_rst_n    (rst_n),
      .i_start    (sii_start),
      .i_addr     (SAL_SII_ALIAS_WORD),
      .o_fetch    (o_sii_fetch),
      .i_answer   (i_sii_answer),
      .o_done     (sii_done),
      .o_data     (sii_data)
   );

   // ************************************************************
   // Power-on sequence and settings
   // ************************************************************
   sal_state_t  state;          // Sequence state
   sal_state_t  next_state;
   logic [15:0] src_sel;        // Selection setting as software sees it
   logic [15:0] next_src_sel;
   logic [15:0] high_set;       // High byte setting as software sees it
   logic [15:0] next_high_set;
   logic [15:0] act_sel;        // Selection frozen at power-on
   logic [15:0] next_act_sel;
   logic [7:0]  act_high;       // High byte frozen at power-on
   logic [7:0]  next_act_high;
   logic [7:0]  act_rotary;     // Switch frozen at power-on
   logic [7:0]  next_act_rotary;
   logic [15:0] cfg_alias;      // Configured alias register
   logic [15:0] next_cfg_alias;
   sal_store_t  store;          // Backup write pulse
   sal_store_t  next_store;
   logic        sel_wr;         // Write to the selection setting
   logic        high_wr;        // Write to the high byte setting
   logic        sel_ok;         // Selection write value allowed
   logic        high_ok;        // High byte write value allowed
   logic [15:0] switch_alias;   // Alias built from switch and high byte

   assign sel_wr  = i_reg.wr && (i_reg.addr == SAL_ADDR_SRC_SEL);
   assign high_wr = i_reg.wr && (i_reg.addr == SAL_ADDR_HIGH_SET);
   assign sel_ok  = (i_reg.wdata == SAL_SEL_SWITCH) ||
                    (i_reg.wdata == SAL_SEL_SII);
   assign high_ok = (i_reg.wdata <= SAL_HIGH_MAX);
   // Zero switch and zero high byte fall out as alias 0 by construction
   assign switch_alias = {act_high, act_rotary};

   // Next values of the sequence and of the settings
   always_comb begin
      next_state      = state;
      next_src_sel    = src_sel;
      next_high_set   = high_set;
      next_act_sel    = act_sel;
      next_act_high   = act_high;
      next_act_rotary = act_rotary;
      next_cfg_alias  = cfg_alias;
      next_store      = '0;
      nv_start        = 1'b0;
      nv_index        = SAL_ADDR_SRC_SEL;
      sii_start       = 1'b0;
      // Accepted writes only change the stored copy; the active alias
      // waits for the next power-on, so a late edit cannot move it
      if (sel_wr && sel_ok) begin
         next_src_sel = i_reg.wdata;
         next_store   = '{valid: 1'b1, index: SAL_ADDR_SRC_SEL, data: i_reg.wdata};
      end else if (high_wr && high_ok) begin
         next_high_set = i_reg.wdata;
         next_store    = '{valid: 1'b1, index: SAL_ADDR_HIGH_SET, data: i_reg.wdata};
      end
      unique case (state)
         SAL_ST_SEL_GO: begin
            // Selection comes first so the source is known before loading
            nv_start        = 1'b1;
            nv_index        = SAL_ADDR_SRC_SEL;
            next_act_rotary = i_rotary_switch;
            next_state      = SAL_ST_SEL_WAIT;
         end
         SAL_ST_SEL_WAIT: begin
            if (nv_done) begin
               next_act_sel = nv_data;
               next_src_sel = nv_data;
               next_state   = SAL_ST_HIGH_GO;
            end
         end
         SAL_ST_HIGH_GO: begin
            nv_start   = 1'b1;
            nv_index   = SAL_ADDR_HIGH_SET;
            next_state = SAL_ST_HIGH_WAIT;
         end
         SAL_ST_HIGH_WAIT: begin
            if (nv_done) begin
               // Only the low byte is meaningful for an upper alias byte
               next_act_high = nv_data[7:0];
               next_high_set = {8'h00, nv_data[7:0]};
               if (act_sel == SAL_SEL_SWITCH) begin
                  next_cfg_alias = {nv_data[7:0], act_rotary};
                  next_state     = SAL_ST_RUN;
               end else begin
                  // Reserved or unknown stored values fall back to SII
                  next_state = SAL_ST_SII_GO;
               end
            end
         end
         SAL_ST_SII_GO: begin
            sii_start  = 1'b1;
            next_state = SAL_ST_SII_WAIT;
         end
         SAL_ST_SII_WAIT: begin
            if (sii_done) begin
               next_cfg_alias = sii_data;
               next_state     = SAL_ST_RUN;
            end
         end
         SAL_ST_RUN: begin
            // Configured alias is frozen here; ID handshake never writes it
            next_state = SAL_ST_RUN;
         end
      endcase
   end

   // Registers of the sequence
   always_ff @(posedge i_core_clk or negedge rst_n) begin
      if (!rst_n) begin
         state      <= SAL_ST_SEL_GO;
         src_sel    <= SAL_SEL_RESET;
         high_set   <= SAL_HIGH_RESET;
         act_sel    <= SAL_SEL_RESET;
         act_high   <= 8'h00;
         act_rotary <= 8'h00;
         cfg_alias  <= SAL_ZERO;
         store      <= '0;
      end else begin
         state      <= next_state;
         src_sel    <= next_src_sel;
         high_set   <= next_high_set;
         act_sel    <= next_act_sel;
         act_high   <= next_act_high;
         act_rotary <= next_act_rotary;
         cfg_alias  <= next_cfg_alias;
         store      <= next_store;
      end
   end

   // ************************************************************
   // Explicit device ID handshake
   // ************************************************************
   logic [15:0] al_ctrl;        // Control register as written by the master
   logic [15:0] next_al_ctrl;
   logic        id_loaded;      // ID loaded flag
   logic        next_id_loaded;
   logic [15:0] al_code;        // State code register
   logic [15:0] next_al_code;
   logic        alarm_on;       // Any communication alarm present
   logic        id_req;         // ID request bit

   assign alarm_on = |{i_comm_alarm_group_a, i_comm_alarm_group_b, i_comm_alarm_group_c};
   assign id_req   = al_ctrl[SAL_ID_BIT];

   // Next values of the handshake; it waits until the alias is ready
   always_comb begin
      next_al_ctrl   = al_ctrl;
      next_id_loaded = id_loaded;
      next_al_code   = al_code;
      if (i_reg.wr && (i_reg.addr == SAL_ADDR_AL_CTRL)) begin
         next_al_ctrl = i_reg.wdata;
      end
      if (state == SAL_ST_RUN) begin
         if (id_req) begin
            // Alarm code overrides while it lasts, then alias returns
            next_al_code   = alarm_on ? i_comm_alarm_code
                                      : switch_alias;
            next_id_loaded = 1'b1;
         end else if (id_loaded) begin
            next_id_loaded = 1'b0;
            next_al_code   = SAL_ZERO;
         end
      end
   end

   // Registers of the handshake
   always_ff @(posedge i_core_clk or negedge rst_n) begin
      if (!rst_n) begin
         al_ctrl   <= SAL_ZERO;
         id_loaded <= 1'b0;
         al_code   <= SAL_ZERO;
      end else begin
         al_ctrl   <= next_al_ctrl;
         id_loaded <= next_id_loaded;
         al_code   <= next_al_code;
      end
   end

   // ************************************************************
   // Register read port
   // ************************************************************
   logic [15:0] rdata;          // Read data register
   logic [15:0] next_rdata;

   // Read mux; unmapped offsets read as zero
   always_comb begin
      next_rdata = rdata;
      if (i_reg.rd) begin
         unique case (i_reg.addr)
            SAL_ADDR_CFG_ALIAS: next_rdata = cfg_alias;
            SAL_ADDR_AL_CTRL:   next_rdata = al_ctrl;
            SAL_ADDR_AL_STATE:  next_rdata = {10'h000, id_loaded, 5'h00};
            SAL_ADDR_AL_CODE:   next_rdata = al_code;
            SAL_ADDR_HIGH_SET:  next_rdata = high_set;
            SAL_ADDR_SRC_SEL:   next_rdata = src_sel;
            default:            next_rdata = SAL_ZERO;
         endcase
      end
   end

   always_ff @(posedge i_core_clk or negedge rst_n) begin
      if (!rst_n) begin
         rdata <= SAL_ZERO;
      end else begin
         rdata <= next_rdata;
      end
   end

   assign o_reg_rdata   = rdata;
   assign o_store       = store;
   assign o_alias_ready = (state == SAL_ST_RUN);

   // ************************************************************
   // Assertions
   // ************************************************************
   sequence seq_sel_fetched;
      state == SAL_ST_SEL_WAIT && nv_done;
   endsequence

   sequence seq_high_fetched;
      state == SAL_ST_HIGH_WAIT && nv_done;
   endsequence

   sel_first_a: assert property (@(posedge i_core_clk) disable iff (!rst_n)
      state == SAL_ST_HIGH_GO |-> $past(state) == SAL_ST_SEL_WAIT && act_sel == $past(nv_data))
      else $error("Selection not fetched before high byte");

   sii_copy_a: assert property (@(posedge i_core_clk) disable iff (!rst_n)
      state == SAL_ST_SII_WAIT && sii_done |=> cfg_alias == $past(sii_data) && o_alias_ready)
      else $error("SII alias not copied");

   switch_load_a: assert property (@(posedge i_core_clk) disable iff (!rst_n)
      seq_high_fetched ##0 act_sel == SAL_SEL_SWITCH |=>
         cfg_alias == {$past(nv_data[7:0]), act_rotary} && o_alias_ready)
      else $error("Switch alias not loaded");

   sel_reserved_a: assert property (@(posedge i_core_clk) disable iff (!rst_n)
      sel_wr && i_reg.wdata == SAL_SEL_RESERVED && state == SAL_ST_RUN |=>
         $stable(src_sel) && !store.valid)
      else $error("Reserved selection accepted");

   high_range_a: assert property (@(posedge i_core_clk) disable iff (!rst_n)
      high_wr && i_reg.wdata > SAL_HIGH_MAX && state == SAL_ST_RUN |=> $stable(high_set))
      else $error("High byte out of range accepted");

   alias_frozen_a: assert property (@(posedge i_core_clk) disable iff (!rst_n)
      state == SAL_ST_RUN ##1 state == SAL_ST_RUN |-> $stable(cfg_alias) && $stable(act_high))
      else $error("Active alias changed after power-on");

   id_present_a: assert property (@(posedge i_core_clk) disable iff (!rst_n)
      state == SAL_ST_RUN && id_req && !alarm_on |=> al_code == $past(switch_alias) && id_loaded)
      else $error("Alias not presented on ID request");

   id_release_a: assert property (@(posedge i_core_clk) disable iff (!rst_n)
      seq_sel_fetched or (state == SAL_ST_RUN && !id_req && id_loaded) |=>
         state != SAL_ST_RUN || (!id_loaded && al_code == SAL_ZERO))
      else $error("ID loaded or code not cleared");

   alarm_code_a: assert property (@(posedge i_core_clk) disable iff (!rst_n)
      state == SAL_ST_RUN && id_req && alarm_on |=> al_code == $past(i_comm_alarm_code))
      else $error("Alarm code not reported");

endmodule

/* verif/sal_mem_model.sv */
// Word memory model for the backup memory and SII fetch ports
module sal_mem_model
   import sal_pkg::*;
(
   input  wire logic           i_core_clk,
   input  wire sal_fetch_req_t i_fetch,
   input  wire logic [15:0]    i_sel,
   input  wire logic [15:0]    i_high,
   input  wire logic [15:0]    i_sii,
   input  wire logic [3:0]     i_delay,
   output sal_fetch_ans_t      o_answer
);
   // ************************************************************
   // Answer logic
   // ************************************************************
   logic [3:0] wait_cnt; // Cycles waited on this request
   logic       answered; // Ack given, req not yet dropped
   initial begin
      wait_cnt = '0;
      answered = 1'b0;
      o_answer = '0;
   end
   // One ack per request; data toggles outside ack so stale words never pass
   always @(posedge i_core_clk) begin
      o_answer.ack  <= 1'b0;
      o_answer.data <= ~o_answer.data;
      if (!i_fetch.req) begin
         answered <= 1'b0;
         wait_cnt <= '0;
      end else if (!answered && wait_cnt < i_delay) begin
         wait_cnt <= wait_cnt + 4'h1;
      end else if (!answered) begin
         answered      <= 1'b1;
         o_answer.ack  <= 1'b1;
         // A wrong word address gets the inverted alias, so it shows up downstream
         o_answer.data <= (i_fetch.addr == SAL_ADDR_SRC_SEL)   ? i_sel :
                          (i_fetch.addr == SAL_ADDR_HIGH_SET)  ? i_high :
                          (i_fetch.addr == SAL_SII_ALIAS_WORD) ? i_sii : ~i_sii;
      end
   end
endmodule

/* verif/sal_station_alias_loader_bench.sv */
// Self-checking bench for the station alias loader
module sal_station_alias_loader_bench
   import sal_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   // ************************************************************
   // Signals and instances
   // ************************************************************
   logic           i_core_clk;         // 50 MHz clock
   logic           i_rst_n;            // Active low reset
   sal_reg_req_t   reg_req;            // Register request
   logic [15:0]    reg_rdata;          // Register read data
   logic [7:0]     rotary;             // Rotary switch
   logic [7:0]     alarm [3];          // Alarm groups a, b, c
   logic [15:0]    alarm_code;         // Reported alarm code
   sal_fetch_req_t nv_fetch, sii_fetch; // Fetch requests
   sal_fetch_ans_t nv_ans, sii_ans;    // Fetch answers
   sal_store_t     store;              // Setting store pulse
   logic           ready;              // Alias loaded
   logic [15:0]    m_sel, m_high, m_sii; // Memory contents
   int             mismatches, n_compared;
   sal_station_alias_loader sal_station_alias_loader_i (
      .i_core_clk(i_core_clk), .i_rst_n(i_rst_n), .i_reg(reg_req),
      .o_reg_rdata(reg_rdata), .i_rotary_switch(rotary),
      .i_comm_alarm_group_a(alarm[0]), .i_comm_alarm_group_b(alarm[1]),
      .i_comm_alarm_group_c(alarm[2]), .i_comm_alarm_code(alarm_code),
      .o_nv_fetch(nv_fetch), .i_nv_answer(nv_ans), .o_sii_fetch(sii_fetch),
      .i_sii_answer(sii_ans), .o_store(store), .o_alias_ready(ready));
   // Prompt backup memory, slow SII
   sal_mem_model nv_mem_i (.i_core_clk(i_core_clk), .i_fetch(nv_fetch), .i_sel(m_sel),
      .i_high(m_high), .i_sii(m_sii), .i_delay(4'h0), .o_answer(nv_ans));
   sal_mem_model sii_mem_i (.i_core_clk(i_core_clk), .i_fetch(sii_fetch), .i_sel(m_sel),
      .i_high(m_high), .i_sii(m_sii), .i_delay(4'h6), .o_answer(sii_ans));
   initial begin
      i_core_clk = 1'b0;
      forever #10 i_core_clk = ~i_core_clk;
   end
   // ************************************************************
   // Shared tasks
   // ************************************************************
   task automatic stop_test();
      $display("Compared %0d, mismatches %0d", n_compared, mismatches);
      if (mismatches == 0 && n_compared > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask
   task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
      n_compared++;
      if (got !== exp) begin
         mismatches++;
         $display("Error %s expected %h seen %h", name, exp, got);
      end
   endtask
   // One-cycle strobe; read data and store pulse are settled on return
   task automatic bus(input logic w, input logic [15:0] a, input logic [15:0] d);
      @(negedge i_core_clk);
      reg_req = '{rd: !w, wr: w, addr: a, wdata: d};
      @(negedge i_core_clk);
      reg_req = '0;
   endtask
   task automatic rd(input logic [15:0] a, input logic [15:0] exp);
      bus(1'b0, a, 16'h0000);
      chk($sformatf("read %h", a), exp, reg_rdata);
   endtask
   task automatic wr(input logic [15:0] a, input logic [15:0] d, input logic kept);
      bus(1'b1, a, d);
      chk("store valid", {15'h0000, kept}, {15'h0000, store.valid});
      if (kept) begin
         chk("store index", a, store.index);
         chk("store data", d, store.data);
      end
   endtask
   // Reset for 5 cycles then wait for the load under a bound
   task automatic power_on(input logic [15:0] s, h, w, input logic [7:0] r);
      int n;
      m_sel = s;
      m_high = h;
      m_sii = w;
      rotary = r;
      i_rst_n = 1'b0;
      repeat (5) @(negedge i_core_clk);
      i_rst_n = 1'b1;
      // Read taken at the third edge after release, before the fetch lands
      @(negedge i_core_clk);
      rd(SAL_ADDR_SRC_SEL, SAL_SEL_RESET);
      for (n = 0; n < 200 && ready !== 1'b1; n++) @(negedge i_core_clk);
      if (ready !== 1'b1) begin
         mismatches++;
         stop_test();
      end
   endtask
   // ************************************************************
   // Scenarios
   // ************************************************************
   task automatic sii_path();
      power_on(16'h0001, 16'h0012, 16'hbeef, 8'h34);
      rd(SAL_ADDR_CFG_ALIAS, 16'hbeef);
      rd(SAL_ADDR_SRC_SEL, 16'h0001);
   endtask
   task automatic switch_path();
      power_on(16'h0000, 16'h00a5, 16'hbeef, 8'h3c);
      rd(SAL_ADDR_CFG_ALIAS, 16'ha53c);
      power_on(16'h0000, 16'h0000, 16'hbeef, 8'h00);
      rd(SAL_ADDR_CFG_ALIAS, 16'h0000);
   endtask
   // Refused, read-only and late setting writes
   task automatic setting_writes();
      power_on(16'h0000, 16'h00ff, 16'h1111, 8'hff);
      rd(SAL_ADDR_CFG_ALIAS, 16'hffff);
      wr(SAL_ADDR_SRC_SEL, SAL_SEL_RESERVED, 1'b0);
      rd(SAL_ADDR_SRC_SEL, 16'h0000);
      wr(SAL_ADDR_HIGH_SET, 16'h0100, 1'b0);
      rd(SAL_ADDR_HIGH_SET, 16'h00ff);
      wr(SAL_ADDR_SRC_SEL, SAL_SEL_SII, 1'b1);
      wr(SAL_ADDR_HIGH_SET, 16'h0007, 1'b1);
      rd(SAL_ADDR_HIGH_SET, 16'h0007);
      // The ID alias keeps the high byte frozen at power-on
      wr(SAL_ADDR_AL_CTRL, 16'h0020, 1'b0);
      rd(SAL_ADDR_AL_CODE, 16'hffff);
      wr(SAL_ADDR_AL_CTRL, 16'h0000, 1'b0);
      wr(SAL_ADDR_CFG_ALIAS, 16'h5555, 1'b0);
      rd(SAL_ADDR_CFG_ALIAS, 16'hffff);
      rd(16'h0200, 16'h0000);
   endtask
   // ID handshake with each alarm group breaking in
   task automatic id_handshake();
      int g;
      power_on(16'h0001, 16'h0042, 16'h0bad, 8'h17);
      alarm_code = 16'h8100;
      wr(SAL_ADDR_AL_CTRL, 16'h0020, 1'b0);
      rd(SAL_ADDR_AL_STATE, 16'h0020);
      rd(SAL_ADDR_AL_CODE, 16'h4217);
      for (g = 0; g < 3; g++) begin
         alarm[g] = 8'h80 >> g;
         rd(SAL_ADDR_AL_CODE, 16'h8100);
         alarm[g] = 8'h00;
         rd(SAL_ADDR_AL_CODE, 16'h4217);
      end
      wr(SAL_ADDR_AL_CTRL, 16'h0000, 1'b0);
      rd(SAL_ADDR_AL_STATE, 16'h0000);
      rd(SAL_ADDR_AL_CODE, 16'h0000);
      rd(SAL_ADDR_CFG_ALIAS, 16'h0bad);
   endtask
   initial begin
      i_rst_n = 1'b0;
      reg_req = '0;
      rotary = 8'h00;
      alarm = '{default: 8'h00};
      alarm_code = 16'h0000;
      m_sel = 16'h0001;
      m_high = 16'h0000;
      m_sii = 16'h0000;
      mismatches = 0;
      n_compared = 0;
      sii_path();
      switch_path();
      setting_writes();
      id_handshake();
      stop_test();
   end
endmodule
